// ---- shared/wit_consts.svh ----
// Address map, keys, field positions, reset values and prescaler taps of the watchdog timer
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH

`define WIT_ADDR_W 28
`define WIT_A_TIMER_CONTROL_STATUS 28'h5FFFFB8
`define WIT_A_CTR_RD 28'h5FFFFB9
`define WIT_A_RST_WR 28'h5FFFFBA
`define WIT_A_RST_RD 28'h5FFFFBB
`define WIT_A_ISTAT 28'h5FFFFF0
`define WIT_A_ICLR 28'h5FFFFF1
`define WIT_A_IEN 28'h5FFFFF2

`define WIT_KEY_TIMER_CONTROL_STATUS 8'hA5
`define WIT_KEY_CTR 8'h5A
`define WIT_KEY_WATCHDOG_OVERFLOW_FLAG 8'hA5
`define WIT_KEY_RSTB 8'h5A

`define WIT_B_OVF 7
`define WIT_B_MODE 6
`define WIT_B_RUN 5
`define WIT_B_WATCHDOG_OVERFLOW_FLAG 7
`define WIT_B_INTERNAL_RESET_ENABLE 6
`define WIT_B_RESET_TYPE_SELECT 5
`define WIT_CKS_HI 2

`define WIT_TIMER_CONTROL_STATUS_PAD 2'h3
`define WIT_RST_PAD 5'h1F
`define WIT_CTR_RST 8'h00
`define WIT_CTR_MAX 8'hFF
`define WIT_CKS_RST 3'h0
`define WIT_BYTE_ZERO 8'h00
`define WIT_EV_RST 2'h0

`define WIT_EV_ITV 0
`define WIT_EV_WDT 1
`define WIT_NTAPS 8

`define WIT_PRE_W 13
`define WIT_PRE_RST 13'h0000
`define WIT_PRE_ONE 13'h0001
`define WIT_SH0 1
`define WIT_SH1 6
`define WIT_SH2 7
`define WIT_SH3 8
`define WIT_SH4 9
`define WIT_SH5 10
`define WIT_SH6 12
`define WIT_SH7 13

`endif

// ---- shared/wit_pkg.sv ----
// Types shared by the watchdog timer design
package wit_pkg;
    typedef struct packed {
        logic [27:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } wit_bus_t;

    typedef struct packed {
        logic [7:0] ctr;
        logic ovf;
        logic mode;
        logic run;
        logic [2:0] cks;
        logic watchdog_overflow_flag;
        logic internal_reset_enable;
        logic reset_type_select;
        logic arm_ovf;
        logic arm_watchdog_overflow_flag;
        logic [12:0] pre;
        logic [1:0] ev_stat;
        logic [1:0] ev_en;
        logic [7:0] rdata;
        logic itv_req;
        logic wdt_out;
        logic por_req;
        logic man_req;
    } wit_state_t;
endpackage

// ---- rtl/wit_top.sv ----
// Watchdog and interval timer with register port, interrupt block and reset requests
`timescale 1ns/10ps
`default_nettype none
`include "wit_consts.svh"

module wit_top
    import wit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire wit_bus_t bus,
    output logic [7:0] rdata,
    output logic irq,
    output logic interval_req,
    output logic watchdog_overflow_output,
    output logic por_req,
    output logic manual_req
);

    localparam wit_state_t ST_RST = '{
        ctr: `WIT_CTR_RST,
        ovf: 1'b0,
        mode: 1'b0,
        run: 1'b0,
        cks: `WIT_CKS_RST,
        watchdog_overflow_flag: 1'b0,
        internal_reset_enable: 1'b0,
        reset_type_select: 1'b0,
        arm_ovf: 1'b0,
        arm_watchdog_overflow_flag: 1'b0,
        pre: `WIT_PRE_RST,
        ev_stat: `WIT_EV_RST,
        ev_en: `WIT_EV_RST,
        rdata: `WIT_BYTE_ZERO,
        itv_req: 1'b0,
        wdt_out: 1'b0,
        por_req: 1'b0,
        man_req: 1'b0
    };

    localparam int unsigned TAP_SH [`WIT_NTAPS] = '{
        `WIT_SH0, `WIT_SH1, `WIT_SH2, `WIT_SH3,
        `WIT_SH4, `WIT_SH5, `WIT_SH6, `WIT_SH7
    };

    wit_state_t st_q;
    wit_state_t st_d;
    logic [`WIT_NTAPS-1:0] tap_tick;
    logic tick;
    logic ovf_evt;
    logic itv_evt;
    logic wdt_evt;
    logic [7:0] key;
    logic [7:0] wlo;
    logic wr_timer_control_status;
    logic wr_ctr;
    logic wr_watchdog_overflow_flag;
    logic wr_rstb;
    logic any_wr_b8;
    logic any_wr_ba;
    logic ovf_clr;
    logic watchdog_overflow_flag_clr;
    logic [1:0] ev_set;

    // One tick every 2**shift cycles of the prescaler, which counts while run is set and is held at zero while stopped
    for (genvar g = 0; g < `WIT_NTAPS; g++) begin : g_tap
        assign tap_tick[g] = &st_q.pre[TAP_SH[g]-1:0];
    end

    assign tick = tap_tick[st_q.cks];
    assign ovf_evt = st_q.run && tick && !wr_ctr && (st_q.ctr == `WIT_CTR_MAX);
    assign itv_evt = ovf_evt && !st_q.mode;
    assign wdt_evt = ovf_evt && st_q.mode;

    assign key = bus.wdata[15:8];
    assign wlo = bus.wdata[7:0];
    assign any_wr_b8 = bus.wr && (bus.addr == `WIT_A_TIMER_CONTROL_STATUS);
    assign any_wr_ba = bus.wr && (bus.addr == `WIT_A_RST_WR);
    // Keyed writes make a stray store unable to disturb the timer
    assign wr_timer_control_status = any_wr_b8 && (key == `WIT_KEY_TIMER_CONTROL_STATUS);
    assign wr_ctr = any_wr_b8 && (key == `WIT_KEY_CTR);
    assign wr_watchdog_overflow_flag = any_wr_ba && (key == `WIT_KEY_WATCHDOG_OVERFLOW_FLAG);
    assign wr_rstb = any_wr_ba && (key == `WIT_KEY_RSTB);
    assign ovf_clr = wr_timer_control_status && st_q.arm_ovf && !wlo[`WIT_B_OVF];
    assign watchdog_overflow_flag_clr = wr_watchdog_overflow_flag && st_q.arm_watchdog_overflow_flag && !wlo[`WIT_B_WATCHDOG_OVERFLOW_FLAG];
    assign ev_set = {wdt_evt, itv_evt};

    always_comb begin
        st_d = st_q;
        st_d.itv_req = 1'b0;
        st_d.wdt_out = 1'b0;
        st_d.por_req = 1'b0;
        st_d.man_req = 1'b0;
        st_d.rdata = `WIT_BYTE_ZERO;

        if (wr_timer_control_status) begin
            st_d.mode = wlo[`WIT_B_MODE];
            st_d.run = wlo[`WIT_B_RUN];
            st_d.cks = wlo[`WIT_CKS_HI:0];
            st_d.arm_ovf = 1'b0;
        end else if (any_wr_b8) begin
            st_d.arm_ovf = 1'b0;
        end
        if (ovf_clr) begin
            st_d.ovf = 1'b0;
        end

        if (wr_rstb) begin
            st_d.internal_reset_enable = wlo[`WIT_B_INTERNAL_RESET_ENABLE];
            st_d.reset_type_select = wlo[`WIT_B_RESET_TYPE_SELECT];
        end
        if (any_wr_ba) begin
            st_d.arm_watchdog_overflow_flag = 1'b0;
        end
        if (watchdog_overflow_flag_clr) begin
            st_d.watchdog_overflow_flag = 1'b0;
        end

        // Counter and prescaler
        if (wr_ctr) begin
            st_d.ctr = wlo;
        end else if (st_q.run && tick) begin
            st_d.ctr = st_q.ctr + 8'h01;
        end
        st_d.pre = st_q.run ? st_q.pre + `WIT_PRE_ONE : `WIT_PRE_RST;

        // Overflow actions; a set in the same cycle as a clear wins
        if (itv_evt) begin
            st_d.ovf = 1'b1;
            st_d.itv_req = 1'b1;
        end
        if (wdt_evt) begin
            st_d.watchdog_overflow_flag = 1'b1;
            st_d.wdt_out = 1'b1;
            st_d.por_req = st_q.internal_reset_enable && !st_q.reset_type_select;
            st_d.man_req = st_q.internal_reset_enable && st_q.reset_type_select;
            // Timer returns to reset state either way; the chip reset is outside
            st_d.ctr = `WIT_CTR_RST;
            st_d.mode = 1'b0;
            st_d.run = 1'b0;
            st_d.cks = `WIT_CKS_RST;
            st_d.ovf = 1'b0;
            st_d.arm_ovf = 1'b0;
            st_d.pre = `WIT_PRE_RST;
        end

        // A stopped counter sits at zero and ignores counter writes
        if (!st_d.run) begin
            st_d.ctr = `WIT_CTR_RST;
        end

        // Interrupt block: sticky status, write-one clear, set wins
        if (bus.wr && (bus.addr == `WIT_A_ICLR)) begin
            st_d.ev_stat = st_q.ev_stat & ~wlo[1:0];
        end
        if (bus.wr && (bus.addr == `WIT_A_IEN)) begin
            st_d.ev_en = wlo[1:0];
        end
        st_d.ev_stat = st_d.ev_stat | ev_set;

        // Read path, answer in the next cycle; unmapped reads give zero
        if (bus.rd) begin
            if (bus.addr == `WIT_A_TIMER_CONTROL_STATUS) begin
                st_d.rdata = {st_q.ovf, st_q.mode, st_q.run, `WIT_TIMER_CONTROL_STATUS_PAD, st_q.cks};
                if (st_q.ovf) begin
                    st_d.arm_ovf = 1'b1;
                end
            end else if (bus.addr == `WIT_A_CTR_RD) begin
                st_d.rdata = st_q.ctr;
            end else if (bus.addr == `WIT_A_RST_RD) begin
                st_d.rdata = {st_q.watchdog_overflow_flag, st_q.internal_reset_enable, st_q.reset_type_select, `WIT_RST_PAD};
                if (st_q.watchdog_overflow_flag) begin
                    st_d.arm_watchdog_overflow_flag = 1'b1;
                end
            end else if (bus.addr == `WIT_A_ISTAT) begin
                st_d.rdata = {6'h00, st_q.ev_stat};
            end else if (bus.addr == `WIT_A_IEN) begin
                st_d.rdata = {6'h00, st_q.ev_en};
            end else begin
                st_d.rdata = `WIT_BYTE_ZERO;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_RST;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign irq = |(st_q.ev_stat & st_q.ev_en);
    assign interval_req = st_q.itv_req;
    assign watchdog_overflow_output = st_q.wdt_out;
    assign por_req = st_q.por_req;
    assign manual_req = st_q.man_req;

    a_itv_flag_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && itv_evt) |=> st_q.ovf)
        else $error("interval overflow flag not set");

    a_itv_flag_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(st_q.ovf) |-> $past(ovf_clr) || $past(wdt_evt))
        else $error("interval flag cleared without read then write zero");

    a_itv_request: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && ovf_evt && !st_q.mode) |=> interval_req && !watchdog_overflow_output)
        else $error("interval request missing");

    a_wdt_output: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && ovf_evt && st_q.mode) |=> watchdog_overflow_output && !interval_req)
        else $error("watchdog output missing");

    a_stop_holds: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !st_q.run |-> (st_q.ctr == `WIT_CTR_RST))
        else $error("stopped counter not zero");

    a_start_counts: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_timer_control_status && wlo[`WIT_B_RUN] && !wdt_evt) |=> st_q.run)
        else $error("run enable did not start counter");

    a_tap_period: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && st_q.run && st_q.cks == `WIT_CKS_RST && !wr_ctr && !bus.wr && tick) |=>
        !tick)
        else $error("divide by two tap ticks twice in a row");

    a_reset_with_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (por_req || manual_req) |-> watchdog_overflow_output && $past(st_q.internal_reset_enable))
        else $error("internal reset not paired with watchdog output");

    a_watchdog_overflow_flag_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wdt_evt) |=> st_q.watchdog_overflow_flag)
        else $error("watchdog flag not set");

    a_watchdog_overflow_flag_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(st_q.watchdog_overflow_flag) |-> $past(watchdog_overflow_flag_clr))
        else $error("watchdog flag cleared without read then write zero");

    a_noreset_reinit: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wdt_evt && !st_q.internal_reset_enable) |=>
        !por_req && !manual_req && !st_q.run && !st_q.mode && st_q.ctr == `WIT_CTR_RST)
        else $error("reset disabled overflow misbehaved");

    a_reset_kind: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wdt_evt && st_q.internal_reset_enable) |=> (manual_req == $past(st_q.reset_type_select)) &&
        (por_req == !$past(st_q.reset_type_select)))
        else $error("wrong internal reset kind");

    a_count_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && st_q.run && tick && !bus.wr && st_q.ctr != `WIT_CTR_MAX) |=>
        st_q.ctr == $past(st_q.ctr) + 8'h01)
        else $error("counter did not step on tick");

    a_ctr_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus.rd && bus.addr == `WIT_A_CTR_RD) |=> rdata == $past(st_q.ctr))
        else $error("counter read wrong");

    a_rst_pad_ones: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus.rd && bus.addr == `WIT_A_RST_RD) |=> rdata[4:0] == `WIT_RST_PAD)
        else $error("reset control unused bits not one");

    a_timer_control_status_pad_ones: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus.rd && bus.addr == `WIT_A_TIMER_CONTROL_STATUS) |=> rdata[4:3] == `WIT_TIMER_CONTROL_STATUS_PAD)
        else $error("control unused bits not one");

    a_bad_key: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && any_wr_b8 && key != `WIT_KEY_TIMER_CONTROL_STATUS && key != `WIT_KEY_CTR && !ovf_evt) |=>
        $stable(st_q.mode) && $stable(st_q.cks))
        else $error("unkeyed write changed control");

    a_freeze_all: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !clk_en |=> $stable(st_q))
        else $error("state moved while clock enable low");

    a_itv_pulse_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && interval_req) |=> !interval_req)
        else $error("interval request longer than one cycle");

    a_wdt_pulse_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && watchdog_overflow_output) |=> !watchdog_overflow_output)
        else $error("watchdog output longer than one cycle");

    a_wdt_reinit: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wdt_evt) |=> !st_q.run && !st_q.ovf && st_q.cks == `WIT_CKS_RST)
        else $error("control not reinitialised on watchdog overflow");

    a_pre_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && !st_q.run) |=> st_q.pre == `WIT_PRE_RST)
        else $error("prescaler moved while stopped");

    a_ctr_write_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_ctr && st_q.run) |=> st_q.ctr == $past(wlo))
        else $error("keyed counter write lost");

    a_ctr_write_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_ctr && !st_q.run) |=> st_q.ctr == `WIT_CTR_RST)
        else $error("stopped counter took a write");

    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && !bus.rd) |=> rdata == `WIT_BYTE_ZERO)
        else $error("read data without a read");

    a_internal_reset_enable_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_rstb && wlo[`WIT_B_INTERNAL_RESET_ENABLE]) |=> st_q.internal_reset_enable)
        else $error("reset enable write lost");

    a_reset_type_select_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_rstb && !wlo[`WIT_B_RESET_TYPE_SELECT]) |=> !st_q.reset_type_select)
        else $error("reset select write lost");

    a_rst_bad_key: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && any_wr_ba && key != `WIT_KEY_WATCHDOG_OVERFLOW_FLAG && key != `WIT_KEY_RSTB) |=>
        $stable(st_q.internal_reset_enable) && $stable(st_q.reset_type_select))
        else $error("unkeyed write changed reset control");

    a_watchdog_overflow_flag_one_noop: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_watchdog_overflow_flag && wlo[`WIT_B_WATCHDOG_OVERFLOW_FLAG] && st_q.watchdog_overflow_flag) |=> st_q.watchdog_overflow_flag)
        else $error("writing one cleared watchdog flag");

    a_ovf_one_noop: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wr_timer_control_status && wlo[`WIT_B_OVF] && st_q.ovf && !wdt_evt) |=> st_q.ovf)
        else $error("writing one cleared interval flag");

    a_ovf_cleared: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && ovf_clr && !itv_evt) |=> !st_q.ovf)
        else $error("armed interval flag not cleared");

    a_watchdog_overflow_flag_cleared: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && watchdog_overflow_flag_clr && !wdt_evt) |=> !st_q.watchdog_overflow_flag)
        else $error("armed watchdog flag not cleared");

    a_wdt_status: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && wdt_evt) |=> st_q.ev_stat[`WIT_EV_WDT])
        else $error("watchdog status bit not set");

    a_itv_status: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && itv_evt) |=> st_q.ev_stat[`WIT_EV_ITV])
        else $error("interval status bit not set");

    a_itv_no_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && itv_evt) |=> !por_req && !manual_req && !watchdog_overflow_output)
        else $error("interval overflow raised watchdog actions");

    a_wr_disarms: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && any_wr_ba && !bus.rd) |=> !st_q.arm_watchdog_overflow_flag)
        else $error("watchdog flag stayed armed after write");

    a_rst_read_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus.rd && bus.addr == `WIT_A_RST_RD) |=> rdata[7] == $past(st_q.watchdog_overflow_flag))
        else $error("watchdog flag read wrong");

    a_timer_control_status_read_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus.rd && bus.addr == `WIT_A_TIMER_CONTROL_STATUS) |=> rdata[7] == $past(st_q.ovf))
        else $error("interval flag read wrong");

endmodule
`default_nettype wire

// ---- test/wit_partner.sv ----
// Model of the interrupt controller and chip reset logic beside the timer
`timescale 1ns/10ps
`default_nettype none
module wit_partner (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic interval_req,
    input wire logic wdt_out,
    input wire logic por_req,
    input wire logic manual_req,
    output logic [7:0] n_itv,
    output logic [7:0] n_wdt,
    output logic [7:0] n_por,
    output logic [7:0] n_man
);
    // Requests are counted, not applied, so the bench keeps its state across them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            n_itv <= 8'h00;
            n_wdt <= 8'h00;
            n_por <= 8'h00;
            n_man <= 8'h00;
        end else begin
            n_itv <= n_itv + 8'(interval_req);
            n_wdt <= n_wdt + 8'(wdt_out);
            n_por <= n_por + 8'(por_req);
            n_man <= n_man + 8'(manual_req);
        end
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the watchdog and interval timer
`timescale 1ns/10ps
`default_nettype none
`include "wit_consts.svh"
module tb
    import wit_pkg::*;
;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    wit_bus_t bus = '0;
    logic [7:0] rdata;
    logic irq, interval_req, wdo, por_req, manual_req;
    logic [7:0] n_itv, n_wdt, n_por, n_man;
    int num_errors = 0;
    int n_checks = 0;

    always #2 sys_clk = ~sys_clk;

    wit_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .bus(bus),
        .rdata(rdata), .irq(irq), .interval_req(interval_req),
        .watchdog_overflow_output(wdo), .por_req(por_req), .manual_req(manual_req));
    wit_partner far (.sys_clk(sys_clk), .arst_n(arst_n), .interval_req(interval_req),
        .wdt_out(wdo), .por_req(por_req), .manual_req(manual_req), .n_itv(n_itv),
        .n_wdt(n_wdt), .n_por(n_por), .n_man(n_man));

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [27:0] a, input logic [15:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rchk(input string name, input logic [27:0] a, input logic [7:0] exp);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        chk(name, {8'h00, rdata}, {8'h00, exp});
        @(posedge sys_clk);
    endtask

    task automatic ichk(input logic exp);
        #1;
        chk("irq", {15'h0000, irq}, {15'h0000, exp});
        @(posedge sys_clk);
    endtask

    // Bounded wait for either overflow pulse; snapshot taken in the pulse cycle
    task automatic wait_ovf(output logic [3:0] s);
        int n;
        n = 0;
        #1;
        while (interval_req !== 1'b1 && wdo !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        s = {interval_req, wdo, por_req, manual_req};
        @(posedge sys_clk);
    endtask

    task automatic t_reset;
        rchk("ctrl", `WIT_A_TIMER_CONTROL_STATUS, 8'h18);
        rchk("count", `WIT_A_CTR_RD, 8'h00);
        rchk("rstctl", `WIT_A_RST_RD, 8'h1F);
        rchk("unmapped", 28'h5FFFFF8, 8'h00);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'h1234);
        rchk("ctrl", `WIT_A_TIMER_CONTROL_STATUS, 8'h18);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'h5A77);
        rchk("count", `WIT_A_CTR_RD, 8'h00);
        wr(`WIT_A_RST_WR, 16'h5A00);
        rchk("rstctl", `WIT_A_RST_RD, 8'h1F);
    endtask

    // Counter is read every cycle; the gap between two steps is the divider
    task automatic t_prescale;
        logic [7:0] v, p;
        int k, k1, d;
        int divs[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
        for (int c = 0; c < 8; c++) begin
            wr(`WIT_A_TIMER_CONTROL_STATUS, {8'hA5, 5'h04, 3'(c)});
            bus.addr <= `WIT_A_CTR_RD;
            bus.rd <= 1'b1;
            k = 0;
            k1 = -1;
            d = 0;
            while (d == 0 && k < 3 * divs[c] + 8) begin
                @(posedge sys_clk);
                #1;
                v = rdata;
                if (k > 0 && v !== p) begin
                    d = (k1 < 0) ? 0 : k - k1;
                    k1 = (k1 < 0) ? k : k1;
                end
                p = v;
                k++;
            end
            @(posedge sys_clk);
            bus.rd <= 1'b0;
            @(posedge sys_clk);
            chk("tick gap", 16'(d), 16'(divs[c]));
        end
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'h5A3C);
        rchk("count", `WIT_A_CTR_RD, 8'h3C);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA500);
        rchk("count", `WIT_A_CTR_RD, 8'h00);
    endtask

    // Clock enable low freezes counter and prescaler; counting resumes after
    task automatic t_freeze;
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA520);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'h5A10);
        clk_en <= 1'b0;
        repeat (20) @(posedge sys_clk);
        clk_en <= 1'b1;
        rchk("frozen count", `WIT_A_CTR_RD, 8'h10);
        rchk("resumed count", `WIT_A_CTR_RD, 8'h11);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA500);
    endtask

    task automatic t_interval;
        logic [3:0] s;
        wr(`WIT_A_IEN, 16'h0003);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA520);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'h5AFE);
        wait_ovf(s);
        chk("outputs", {12'h000, s}, 16'h0008);
        ichk(1'b1);
        rchk("ctrl", `WIT_A_TIMER_CONTROL_STATUS, 8'hB8);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA5A0);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA520);
        rchk("ctrl", `WIT_A_TIMER_CONTROL_STATUS, 8'hB8);
        wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA500);
        rchk("ctrl", `WIT_A_TIMER_CONTROL_STATUS, 8'h18);
        rchk("status", `WIT_A_ISTAT, 8'h01);
        wr(`WIT_A_IEN, 16'h0002);
        ichk(1'b0);
        wr(`WIT_A_IEN, 16'h0003);
        ichk(1'b1);
        wr(`WIT_A_ICLR, 16'h0001);
        ichk(1'b0);
    endtask

    task automatic t_watchdog;
        logic [3:0] s;
        logic e, m;
        for (int i = 0; i < 3; i++) begin
            e = (i > 0);
            m = (i == 2);
            wr(`WIT_A_RST_WR, {8'h5A, 1'b0, e, m, 5'h00});
            wr(`WIT_A_TIMER_CONTROL_STATUS, 16'hA560);
            wr(`WIT_A_TIMER_CONTROL_STATUS, 16'h5AFE);
            wait_ovf(s);
            chk("outputs", {12'h000, s}, {12'h000, 2'h1, e & !m, e & m});
            rchk("ctrl", `WIT_A_TIMER_CONTROL_STATUS, 8'h18);
            rchk("count", `WIT_A_CTR_RD, 8'h00);
            rchk("rstctl", `WIT_A_RST_RD, {1'b1, e, m, 5'h1F});
            wr(`WIT_A_RST_WR, 16'hA580);
            wr(`WIT_A_RST_WR, 16'hA500);
            rchk("rstctl", `WIT_A_RST_RD, {1'b1, e, m, 5'h1F});
            wr(`WIT_A_RST_WR, 16'hA500);
            rchk("rstctl", `WIT_A_RST_RD, {1'b0, e, m, 5'h1F});
        end
        rchk("status", `WIT_A_ISTAT, 8'h02);
        chk("far counts", {n_itv, n_wdt}, 16'h0103);
        chk("far resets", {n_por, n_man}, 16'h0101);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_prescale;
        t_freeze;
        t_interval;
        t_watchdog;
        end_of_test;
    end

    // The full run needs about 25k cycles; this allows well over double
    initial begin
        #400000;
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
